// ===== rtl/deep_sleep_clock_switch_defines.svh
/*
 Register offsets, field positions and reset values for the deep-sleep
 clock switch. Assumes inclusion by bare name from the package and module.
*/
`ifndef DEEP_SLEEP_CLOCK_SWITCH_DEFINES_SVH
`define DEEP_SLEEP_CLOCK_SWITCH_DEFINES_SVH

`define ADDR_W 12
`define OFS_DS_CFG 12'h144
`define OFS_CHK_CLR 12'h150
`define OFS_FAULT_STAT 12'h154
`define OFS_INT_STAT 12'h158
`define OFS_INT_MASK 12'h15C

`define BIT_OVERRIDE 0
`define BIT_VER_CLR 0
`define INT_ENTRY 0
`define INT_EXIT 1
`define INT_FAULT 2
`define INT_W 3

`define SRC_W 2
`define DIV_W 4
`define SRC_MAIN 2'h0
`define SRC_INTERNAL 2'h1
`define DIV_RESET 4'h0
`define WORD_ZERO 32'h00000000

`endif

// ===== rtl/deep_sleep_clock_switch_pkg.sv
/*
 Types shared by the deep-sleep clock switch.
 Assumes the defines header is on the include path.
*/
`include "deep_sleep_clock_switch_defines.svh"

package deep_sleep_clock_switch_pkg;

    typedef logic [`SRC_W-1:0] clk_src_t;
    typedef logic [`DIV_W-1:0] clk_div_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } reg_req_s;

    typedef struct packed {
        clk_src_t src;
        clk_div_t div;
        logic int_osc_en;
        logic main_osc_en;
        logic force_good;
    } clk_ctrl_s;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP_OVERRIDE,
        ST_SLEEP_PLAIN
    } sleep_state_e;

endpackage

// ===== rtl/deep_sleep_clock_switch.sv
/*
 Deep-sleep clock source override and clock verification fault clearing.
 Assumes the run-mode source/divider, sleep entry/exit pulses and fault
 events all come from logic on clk; the clock mux itself lies outside.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_switch_defines.svh"

module deep_sleep_clock_switch #(
    parameter int NUM_FAULTS = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire deep_sleep_clock_switch_pkg::reg_req_s req,
    output logic [31:0] rdata,
    input wire deep_sleep_clock_switch_pkg::clk_src_t run_src,
    input wire deep_sleep_clock_switch_pkg::clk_div_t run_div,
    input wire logic deep_sleep_enter,
    input wire logic deep_sleep_exit,
    input wire logic [NUM_FAULTS-1:0] fault_evt,
    output deep_sleep_clock_switch_pkg::clk_ctrl_s clk_ctrl,
    output logic [NUM_FAULTS-1:0] fault_active,
    output logic irq
);
    import deep_sleep_clock_switch_pkg::*;

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [31:0] bit_word(input logic b);
        bit_word = {31'h00000000, b};
    endfunction

    // register file
    logic override_q, override_d;
    logic ver_clr_q, ver_clr_d;
    logic [`INT_W-1:0] int_stat_q, int_stat_d;
    logic [`INT_W-1:0] int_mask_q, int_mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;

    // sleep sequencing and clock control
    sleep_state_e state_q, state_d;
    clk_src_t saved_src_q, saved_src_d;
    clk_div_t saved_div_q, saved_div_d;
    clk_ctrl_s ctrl_q, ctrl_d;
    logic [NUM_FAULTS-1:0] fault_q, fault_d;

    logic wr_cfg, wr_clr, wr_stat, wr_mask;
    logic entry_ev, exit_ev, fault_ev;

    // the internal oscillator must run whenever it is the chosen source
    function automatic logic needs_int_osc(input clk_src_t s);
        needs_int_osc = (s == `SRC_INTERNAL);
    endfunction

    // write strobes are decoded once here and shared by the control-bit and interrupt status groups below
    always_comb
    begin
        wr_cfg = req.we && hit(req.addr, `OFS_DS_CFG);
        wr_clr = req.we && hit(req.addr, `OFS_CHK_CLR);
        wr_stat = req.we && hit(req.addr, `OFS_INT_STAT);
        wr_mask = req.we && hit(req.addr, `OFS_INT_MASK);
    end

    // software-owned control bits
    always_comb
    begin
        override_d = override_q;
        if (wr_cfg)
        begin
            override_d = req.wdata[`BIT_OVERRIDE];
        end
        // hardware never touches this bit; only writes change it
        ver_clr_d = ver_clr_q;
        if (wr_clr)
        begin
            ver_clr_d = req.wdata[`BIT_VER_CLR];
        end
        // the mask only gates the line; it never clears status bits
        int_mask_d = int_mask_q;
        if (wr_mask)
        begin
            int_mask_d = req.wdata[`INT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            override_q <= 1'b0;
            ver_clr_q <= 1'b0;
            int_mask_q <= '0;
        end
        else
        begin
            override_q <= override_d;
            ver_clr_q <= ver_clr_d;
            int_mask_q <= int_mask_d;
        end
    end

    // read data stand for one cycle and fall back to zero after it
    always_comb
    begin
        rdata_d = `WORD_ZERO;
        if (req.re)
        begin
            unique case (1'b1)
                hit(req.addr, `OFS_DS_CFG):
                    rdata_d = bit_word(override_q);
                hit(req.addr, `OFS_CHK_CLR):
                    rdata_d = bit_word(ver_clr_q);
                hit(req.addr, `OFS_FAULT_STAT):
                    rdata_d = {{(32-NUM_FAULTS){1'b0}}, fault_q};
                hit(req.addr, `OFS_INT_STAT):
                    rdata_d = {{(32-`INT_W){1'b0}}, int_stat_q};
                hit(req.addr, `OFS_INT_MASK):
                    rdata_d = {{(32-`INT_W){1'b0}}, int_mask_q};
                // unmapped offsets fall through and read as zero
                default: rdata_d = `WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= `WORD_ZERO;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // enter is taken only while running, exit only while asleep
    always_comb
    begin
        state_d = state_q;
        saved_src_d = saved_src_q;
        saved_div_d = saved_div_q;
        entry_ev = 1'b0;
        exit_ev = 1'b0;
        unique case (state_q)
            ST_RUN:
                if (deep_sleep_enter)
                begin
                    entry_ev = 1'b1;
                    // remember what was running so exit can restore it
                    saved_src_d = run_src;
                    saved_div_d = run_div;
                    state_d = override_q ? ST_SLEEP_OVERRIDE
                                         : ST_SLEEP_PLAIN;
                end
            // a second enter while asleep is ignored, not queued
            ST_SLEEP_OVERRIDE, ST_SLEEP_PLAIN:
                if (deep_sleep_exit)
                begin
                    exit_ev = 1'b1;
                    state_d = ST_RUN;
                end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_RUN;
            saved_src_q <= `SRC_MAIN;
            saved_div_q <= `DIV_RESET;
        end
        else
        begin
            state_q <= state_d;
            saved_src_q <= saved_src_d;
            saved_div_q <= saved_div_d;
        end
    end

    // verification faults are sticky until the clear bit is raised
    always_comb
    begin
        // while clear is held, detection is suppressed; clear wins here
        if (ver_clr_q)
        begin
            fault_d = '0;
        end
        else
        begin
            fault_d = fault_q | fault_evt;
        end
        fault_ev = (|fault_evt) && !ver_clr_q;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_q <= '0;
        end
        else
        begin
            fault_q <= fault_d;
        end
    end

    // clock control is registered so the mux outside sees clean levels
    always_comb
    begin
        ctrl_d.force_good = |fault_d;
        if (state_d == ST_SLEEP_OVERRIDE || ctrl_d.force_good)
        begin
            // internal oscillator doubles as the known good clock
            ctrl_d.src = `SRC_INTERNAL;
            ctrl_d.div = `DIV_RESET;
            ctrl_d.int_osc_en = 1'b1;
            ctrl_d.main_osc_en = (state_d != ST_SLEEP_OVERRIDE);
        end
        else if (state_d == ST_SLEEP_PLAIN)
        begin
            // plain sleep holds the entry source even if run config moves
            ctrl_d.src = saved_src_d;
            ctrl_d.div = saved_div_d;
            ctrl_d.int_osc_en = needs_int_osc(saved_src_d);
            ctrl_d.main_osc_en = 1'b1;
        end
        else if (exit_ev)
        begin
            // restore exactly what was latched at entry
            ctrl_d.src = saved_src_q;
            ctrl_d.div = saved_div_q;
            ctrl_d.int_osc_en = needs_int_osc(saved_src_q);
            ctrl_d.main_osc_en = 1'b1;
        end
        else
        begin
            // running: follow the run-mode selection as it changes
            ctrl_d.src = run_src;
            ctrl_d.div = run_div;
            ctrl_d.int_osc_en = needs_int_osc(run_src);
            ctrl_d.main_osc_en = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q.src <= `SRC_MAIN;
            ctrl_q.div <= `DIV_RESET;
            ctrl_q.int_osc_en <= 1'b0;
            ctrl_q.main_osc_en <= 1'b1;
            ctrl_q.force_good <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // write-one-to-clear, a new event in the same cycle wins
    always_comb
    begin
        int_stat_d = int_stat_q;
        if (wr_stat)
        begin
            int_stat_d = int_stat_q & ~req.wdata[`INT_W-1:0];
        end
        int_stat_d[`INT_ENTRY] = int_stat_d[`INT_ENTRY] | entry_ev;
        int_stat_d[`INT_EXIT] = int_stat_d[`INT_EXIT] | exit_ev;
        int_stat_d[`INT_FAULT] = int_stat_d[`INT_FAULT] | fault_ev;
        // next-state values, so the line rises with its status bit
        irq_d = |(int_stat_d & int_mask_d);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            int_stat_q <= int_stat_d;
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign clk_ctrl = ctrl_q;
    assign fault_active = fault_q;
    assign irq = irq_q;

endmodule

`default_nettype wire

// ===== tb/dsc_props.sv
/*
 Checker for the deep-sleep clock switch, bound to its top module.
 Assumes the register map of the defines header and a single clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_switch_defines.svh"

module dsc_props #(
    parameter int NUM_FAULTS = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire deep_sleep_clock_switch_pkg::reg_req_s req,
    input wire logic [31:0] rdata,
    input wire logic deep_sleep_enter,
    input wire logic deep_sleep_exit,
    input wire logic [NUM_FAULTS-1:0] fault_evt,
    input wire deep_sleep_clock_switch_pkg::clk_ctrl_s clk_ctrl,
    input wire logic [NUM_FAULTS-1:0] fault_active
);
    import deep_sleep_clock_switch_pkg::*;
    logic ovr_q;
    logic clr_q;
    // shadows of the two software bits, so reads tie back to writes
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            {ovr_q, clr_q} <= 2'h0;
        else if (req.we && req.addr == `OFS_DS_CFG)
            ovr_q <= req.wdata[0];
        else if (req.we && req.addr == `OFS_CHK_CLR)
            clr_q <= req.wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence rd_cfg;
        req.re && req.addr == `OFS_DS_CFG;
    endsequence
    sequence rd_clr;
        req.re && req.addr == `OFS_CHK_CLR;
    endsequence
    a_reset_main: assert property (
        $rose(arst_n) |-> clk_ctrl.src == `SRC_MAIN && clk_ctrl.main_osc_en)
        else $error("source not main after reset");
    a_enter_override: assert property (
        deep_sleep_enter && ovr_q && clk_ctrl.main_osc_en |=>
        clk_ctrl.src == `SRC_INTERNAL && clk_ctrl.int_osc_en &&
        !clk_ctrl.main_osc_en) else $error("override entry wrong");
    a_exit_main: assert property (
        deep_sleep_exit && !clk_ctrl.main_osc_en |=> clk_ctrl.main_osc_en)
        else $error("main osc not back on exit");
    a_fault_force: assert property (
        fault_evt != '0 && !clr_q |=> clk_ctrl.force_good &&
        clk_ctrl.src == `SRC_INTERNAL && fault_active != '0)
        else $error("fault did not force good clock");
    a_fault_sticky: assert property (
        fault_active != '0 && !clr_q |=> fault_active != '0)
        else $error("fault dropped without clear");
    a_clear_all: assert property (clr_q |=> fault_active == '0)
        else $error("faults not held clear");
    a_rdata_idle: assert property (!$past(req.re) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_cfg_read: assert property (rd_cfg |=> rdata == {31'h0, ovr_q})
        else $error("config read wrong");
    a_clr_read: assert property (rd_clr |=> rdata == {31'h0, clr_q})
        else $error("clear bit read wrong");
endmodule

bind deep_sleep_clock_switch dsc_props #(.NUM_FAULTS(NUM_FAULTS)) props_i (
    .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .deep_sleep_enter(deep_sleep_enter), .deep_sleep_exit(deep_sleep_exit),
    .fault_evt(fault_evt), .clk_ctrl(clk_ctrl), .fault_active(fault_active));
`default_nettype wire

// ===== tb/test_deep_sleep_clock_switch.sv
/*
 Register-level bench for the deep-sleep clock switch.
 Assumes the defines header on the include path and two fault inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_switch_defines.svh"

module test_deep_sleep_clock_switch;
    import deep_sleep_clock_switch_pkg::*;
    logic clk, arst_n, deep_sleep_enter, deep_sleep_exit, irq;
    reg_req_s req;
    logic [31:0] rdata;
    clk_src_t run_src;
    clk_div_t run_div;
    logic [1:0] fault_evt, fault_active;
    clk_ctrl_s clk_ctrl;
    int err_count, comparisons;
    deep_sleep_clock_switch #(.NUM_FAULTS(2)) uut (.clk(clk),
        .arst_n(arst_n), .req(req), .rdata(rdata), .run_src(run_src),
        .run_div(run_div), .deep_sleep_enter(deep_sleep_enter),
        .deep_sleep_exit(deep_sleep_exit), .fault_evt(fault_evt),
        .clk_ctrl(clk_ctrl), .fault_active(fault_active), .irq(irq));
    always #5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        req.we <= 1'b0;
    endtask
    task gap;
        @(posedge clk);
        @(negedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        req.re <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    task pulse(input logic [3:0] v);
        @(posedge clk);
        {deep_sleep_enter, deep_sleep_exit, fault_evt} <= v;
        @(posedge clk);
        {deep_sleep_enter, deep_sleep_exit, fault_evt} <= 4'h0;
        @(negedge clk);
    endtask
    task set_run(input clk_src_t s, input clk_div_t d);
        @(posedge clk);
        {run_src, run_div} <= {s, d};
    endtask
    task cc(input clk_src_t s, input clk_div_t d, input logic m);
        chk({25'h0, clk_ctrl.src, clk_ctrl.div, clk_ctrl.main_osc_en},
            {25'h0, s, d, m});
    endtask
    task irq_is(input logic e);
        gap();
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task summarize;
        $display("err_count %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // the whole sequence needs about 63 cycles
    initial
    begin
        #50000;
        err_count++;
        summarize();
    end
    initial
    begin
        {clk, arst_n, deep_sleep_enter, deep_sleep_exit, fault_evt} = 5'h0;
        {req, run_src, run_div, err_count, comparisons} = '0;
        run_div = 4'h5;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        cc(`SRC_MAIN, `DIV_RESET, 1'b1);
        rd(`OFS_DS_CFG, 32'h0);
        wr(`OFS_DS_CFG, 32'hFFFFFFFF);
        rd(`OFS_DS_CFG, 32'h1);
        wr(`OFS_INT_MASK, 32'h7);
        pulse(4'h8);
        cc(`SRC_INTERNAL, `DIV_RESET, 1'b0);
        chk({31'h0, clk_ctrl.int_osc_en}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        set_run(`SRC_MAIN, 4'h9);
        pulse(4'h4);
        cc(`SRC_MAIN, 4'h5, 1'b1);
        wr(`OFS_DS_CFG, 32'h0);
        {run_src, run_div} <= {`SRC_INTERNAL, 4'h3};
        pulse(4'h8);
        set_run(`SRC_MAIN, 4'h0);
        gap();
        cc(`SRC_INTERNAL, 4'h3, 1'b1);
        pulse(4'h4);
        cc(`SRC_INTERNAL, 4'h3, 1'b1);
        rd(`OFS_INT_STAT, 32'h3);
        wr(`OFS_INT_STAT, 32'h3);
        rd(`OFS_INT_STAT, 32'h0);
        wr(12'h200, 32'hFFFFFFFF);
        rd(12'h200, 32'h0);
        pulse(4'h3);
        chk({30'h0, fault_active}, 32'h3);
        chk({31'h0, clk_ctrl.force_good}, 32'h1);
        rd(`OFS_FAULT_STAT, 32'h3);
        wr(`OFS_CHK_CLR, 32'h1);
        gap();
        chk({30'h0, fault_active}, 32'h0);
        pulse(4'h1);
        chk({30'h0, fault_active}, 32'h0);
        rd(`OFS_CHK_CLR, 32'h1);
        wr(`OFS_CHK_CLR, 32'h0);
        repeat (2) @(posedge clk);
        pulse(4'h1);
        chk({30'h0, fault_active}, 32'h1);
        wr(`OFS_INT_MASK, 32'h3);
        irq_is(1'b0);
        wr(`OFS_INT_MASK, 32'h4);
        irq_is(1'b1);
        wr(`OFS_INT_STAT, 32'h4);
        irq_is(1'b0);
        summarize();
    end
endmodule
`default_nettype wire
